/* src/rss_consts.svh */
/*
  Constants of the RAM sweep address sequencer: register offsets, field
  positions, reset values and timer figures.
  Assumes a 200 MHz system clock and a plain register port with byte offsets.
*/
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
`define RSS_OFF_CTRL 8'h00
`define RSS_OFF_SEGC0 8'h04
`define RSS_OFF_SEGA0 8'h14
`define RSS_OFF_STATUS 8'h24
`define RSS_RAM_EN_BIT 31
`define RSS_RAM_DEST_BIT 30
`define RSS_IPF_LO 27
`define RSS_MODE_LO 5
`define RSS_NODWELL_BIT 4
`define RSS_RATE_LO 8
`define RSS_BEGIN_LO 0
`define RSS_FINAL_LO 16
`define RSS_ST_ADDR_LO 0
`define RSS_ST_PROF_LO 12
`define RSS_ST_STATE_LO 16
`define RSS_ST_DONE_BIT 20
`define RSS_CTRL_RESET 32'h00000000
`define RSS_SEG_RESET 32'h00000000
`define RSS_TIMER_ONE 16'h0001
`endif

/* src/rss_pkg.sv */
/*
  Types of the RAM sweep address sequencer: sweep states and segment modes.
  Assumes nothing of its surroundings.
*/
package rss_pkg;
  // Sweep engine states, one-hot.
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_HOLD = 4'h2,
    ST_UP = 4'h4,
    ST_DOWN = 4'h8
  } rss_state_t;
  // Decoded segment operating modes.
  typedef enum logic [2:0] {
    MD_DIRECT = 3'h0,
    MD_RAMP_UP = 3'h1,
    MD_BIDIR = 3'h2,
    MD_CONT_BIDIR = 3'h3,
    MD_RECIRC = 3'h4
  } rss_mode_t;
endpackage

/* src/rss_sequencer.sv */
/*
  RAM address generator and profile sequencer of a sweeping synthesizer.
  Assumes a 200 MHz CLOCK, a register master on the same clock, and
  asynchronous profile and transfer pins driven by an outside controller.
*/
`timescale 1ns/100ps
`include "rss_consts.svh"
module rss_sequencer
  import rss_pkg::*;
(
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Pins from the controller.
  input wire logic [1:0] PROFILE_SELECT,
  input wire logic UPDATE,
  // Sweep outputs.
  output logic [9:0] RAM_ADDR,
  output logic RAM_TO_PHASE,
  output logic RAM_ACTIVE,
  output logic [1:0] ACTIVE_PROFILE,
  output logic BURST_DONE
);

  // Buffered registers written by software, active copies used by the engine.
  logic [31:0] buf_ctrl, act_ctrl;
  logic [31:0] buf_segc [4], act_segc [4];
  logic [31:0] buf_sega [4], act_sega [4];

  // Pin synchronisers and filtered levels.
  logic [2:0] sync1, sync2, sync3, filt, filt_d;
  logic upd_rise, xfer_d, ps_chg, ps0_rise, ps0_fall;

  // Engine state.
  rss_state_t st, next_st;
  logic [9:0] addr, next_addr;
  logic [15:0] timer, next_timer;
  logic [1:0] cur_prof, next_prof;
  logic done, next_done;

  // Decoded configuration.
  logic ram_en, seq_on, seq_cont, bidir, start_go, tick;
  logic [2:0] ipf;
  logic [1:0] last_prof, start_prof, seq_next;
  rss_mode_t start_mode, run_mode;
  logic [9:0] cur_begin, cur_final;
  logic [15:0] cur_rate;
  logic [31:0] rd_mux, rd_status;

  // Mode code decode; open codes fall back to direct switch.
  function automatic rss_mode_t decode_mode(input logic [2:0] code);
    rss_mode_t m;
    m = MD_DIRECT;
    case (code)
      3'h1: m = MD_RAMP_UP;
      3'h2: m = MD_BIDIR;
      3'h3: m = MD_CONT_BIDIR;
      3'h4: m = MD_RECIRC;
      default: m = MD_DIRECT;
    endcase
    return m;
  endfunction

  // Three-stage synchronisers; a level counts once stages two and three agree.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      filt <= 3'h0;
      filt_d <= 3'h0;
    end
    else
    begin
      sync1 <= {UPDATE, PROFILE_SELECT};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
      filt_d <= filt;
    end
  end

  // Edge detection on the filtered pins.
  assign upd_rise = filt[2] & ~filt_d[2];
  assign ps_chg = filt[1:0] != filt_d[1:0];
  assign ps0_rise = filt[0] & ~filt_d[0];
  assign ps0_fall = ~filt[0] & filt_d[0];

  // The sweep restarts the cycle after the transfer so it sees new settings.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      xfer_d <= 1'b0;
    else
      xfer_d <= upd_rise;
  end

  // Control register: software write to buffer, strobe moves it to active.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      buf_ctrl <= `RSS_CTRL_RESET;
      act_ctrl <= `RSS_CTRL_RESET;
    end
    else
    begin
      if (WR && ADDR == `RSS_OFF_CTRL)
        buf_ctrl <= WDATA;
      if (upd_rise)
        act_ctrl <= buf_ctrl;
    end
  end

  // Per-profile segment control and address words.
  for (genvar i = 0; i < 4; i++)
  begin : g_seg
    localparam logic [7:0] CADDR = `RSS_OFF_SEGC0 + 8'(4 * i);
    localparam logic [7:0] AADDR = `RSS_OFF_SEGA0 + 8'(4 * i);
    always_ff @(posedge CLOCK)
    begin
      if (RST)
      begin
        buf_segc[i] <= `RSS_SEG_RESET;
        act_segc[i] <= `RSS_SEG_RESET;
        buf_sega[i] <= `RSS_SEG_RESET;
        act_sega[i] <= `RSS_SEG_RESET;
      end
      else
      begin
        if (WR && ADDR == CADDR)
          buf_segc[i] <= WDATA;
        if (WR && ADDR == AADDR)
          buf_sega[i] <= WDATA;
        if (upd_rise)
        begin
          act_segc[i] <= buf_segc[i];
          act_sega[i] <= buf_sega[i];
        end
      end
    end
  end

  // Configuration decode.
  assign ram_en = act_ctrl[`RSS_RAM_EN_BIT];
  assign ipf = act_ctrl[`RSS_IPF_LO +: 3];
  assign seq_on = ram_en && ipf != 3'h0 && ipf != 3'h7;
  assign seq_cont = ipf[2];
  assign last_prof = ipf[2] ? ipf[1:0] + 2'h1 : ipf[1:0];
  assign bidir = ram_en && !seq_on
    && decode_mode(act_segc[0][`RSS_MODE_LO +: 3]) == MD_BIDIR;
  // Bidirectional ramp and sequencing both pin the start to profile zero.
  assign start_prof = (seq_on || bidir) ? 2'h0 : filt[1:0];
  assign start_mode = seq_on ? MD_RAMP_UP
    : decode_mode(act_segc[start_prof][`RSS_MODE_LO +: 3]);
  assign run_mode = seq_on ? MD_RAMP_UP
    : decode_mode(act_segc[cur_prof][`RSS_MODE_LO +: 3]);
  // Pin changes restart only when the pins select profiles.
  assign start_go = ram_en
    && (xfer_d || (ps_chg && !seq_on && !bidir));
  assign cur_begin = act_sega[cur_prof][`RSS_BEGIN_LO +: 10];
  assign cur_final = act_sega[cur_prof][`RSS_FINAL_LO +: 10];
  assign cur_rate = act_segc[cur_prof][`RSS_RATE_LO +: 16];
  assign seq_next = (cur_prof == last_prof) ? 2'h0 : cur_prof + 2'h1;
  // A rate of zero or one gives a one-cycle step period.
  assign tick = timer <= `RSS_TIMER_ONE;

  // Next-state logic of the address generator and timer.
  always_comb
  begin
    next_st = st;
    next_addr = addr;
    next_prof = cur_prof;
    next_done = done;
    next_timer = tick ? cur_rate : timer - 16'h1;
    if (!ram_en)
    begin
      next_st = ST_OFF;
      next_done = 1'b0;
    end
    else if (start_go)
    begin
      next_prof = start_prof;
      next_addr = act_sega[start_prof][`RSS_BEGIN_LO +: 10];
      next_timer = act_segc[start_prof][`RSS_RATE_LO +: 16];
      next_done = 1'b0;
      case (start_mode)
        MD_DIRECT: next_st = ST_HOLD;
        MD_BIDIR: next_st = filt[0] ? ST_UP : ST_DOWN;
        default: next_st = ST_UP;
      endcase
    end
    else if (bidir && ps0_fall)
    begin
      next_st = ST_DOWN;
      next_timer = cur_rate;
      if (addr != cur_begin)
        next_addr = addr - 10'h1;
    end
    else if (bidir && ps0_rise)
    begin
      next_st = ST_UP;
      next_timer = cur_rate;
    end
    else if (tick)
    begin
      unique case (st)
        ST_OFF, ST_HOLD: next_st = st;
        ST_UP:
        begin
          // The no-dwell flag is not consulted in any sweep here.
          if (addr != cur_final)
            next_addr = addr + 10'h1;
          else if (seq_on)
          begin
            if (cur_prof != last_prof || seq_cont)
            begin
              next_prof = seq_next;
              next_addr = act_sega[seq_next][`RSS_BEGIN_LO +: 10];
              next_timer = act_segc[seq_next][`RSS_RATE_LO +: 16];
            end
            else
            begin
              next_st = ST_HOLD;
              next_done = 1'b1;
            end
          end
          else if (run_mode == MD_CONT_BIDIR)
          begin
            next_st = ST_DOWN;
            if (addr != cur_begin)
              next_addr = addr - 10'h1;
          end
          else if (run_mode == MD_RECIRC)
            next_addr = cur_begin;
        end
        ST_DOWN:
        begin
          if (addr != cur_begin)
            next_addr = addr - 10'h1;
          else if (run_mode == MD_CONT_BIDIR && !bidir)
          begin
            next_st = ST_UP;
            if (addr != cur_final)
              next_addr = addr + 10'h1;
          end
        end
        default: next_st = ST_OFF;
      endcase
    end
  end

  // Engine state registers.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      st <= ST_OFF;
      addr <= 10'h0;
      timer <= 16'h0;
      cur_prof <= 2'h0;
      done <= 1'b0;
    end
    else
    begin
      st <= next_st;
      addr <= next_addr;
      timer <= next_timer;
      cur_prof <= next_prof;
      done <= next_done;
    end
  end

  // Outputs; the address feeds the RAM whichever destination is chosen.
  assign RAM_ADDR = addr;
  assign RAM_TO_PHASE = act_ctrl[`RSS_RAM_DEST_BIT];
  assign RAM_ACTIVE = st != ST_OFF;
  assign ACTIVE_PROFILE = cur_prof;
  assign BURST_DONE = done;

  // Status word showing the live engine state.
  always_comb
  begin
    rd_status = 32'h0;
    rd_status[`RSS_ST_ADDR_LO +: 10] = addr;
    rd_status[`RSS_ST_PROF_LO +: 2] = cur_prof;
    rd_status[`RSS_ST_STATE_LO +: 4] = st;
    rd_status[`RSS_ST_DONE_BIT] = done;
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_mux = 32'h0;
    if (ADDR == `RSS_OFF_CTRL)
      rd_mux = buf_ctrl;
    else if (ADDR == `RSS_OFF_STATUS)
      rd_mux = rd_status;
    for (int k = 0; k < 4; k++)
    begin
      if (ADDR == `RSS_OFF_SEGC0 + 8'(4 * k))
        rd_mux = buf_segc[k];
      if (ADDR == `RSS_OFF_SEGA0 + 8'(4 * k))
        rd_mux = buf_sega[k];
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      RDATA <= 32'h0;
    else
      RDATA <= RD ? rd_mux : 32'h0;
  end

  // Checks of the sweep behaviour.
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  a_off_when_disabled: assert property (!ram_en |=> st == ST_OFF)
    else $error("engine running with RAM disabled");
  a_dest_follows_xfer: assert property (upd_rise |=> RAM_TO_PHASE == $past(buf_ctrl[30]))
    else $error("destination not taken from transfer");
  a_segbits_mode: assert property (xfer_d && ram_en && !seq_on
      && act_segc[0][7:5] == 3'h2 |=> cur_prof == 2'h0)
    else $error("mode field not at bits 7 to 5");
  a_bidir_prof_zero: assert property (bidir && st != ST_OFF && !xfer_d
      |-> cur_prof == 2'h0)
    else $error("bidirectional ramp left profile zero");
  a_start_loads: assert property (start_go |=> addr == $past(act_sega[start_prof][9:0])
      && timer == $past(act_segc[start_prof][23:8]))
    else $error("start did not load begin and rate");
  a_up_step: assert property (st == ST_UP && tick && !start_go && ram_en
      && !(bidir && ps_chg) && addr != cur_final |=> addr == $past(addr) + 10'h1)
    else $error("up step missed");
  a_fall_step: assert property (bidir && ps0_fall && !start_go && addr != cur_begin
      |=> addr == $past(addr) - 10'h1 && st == ST_DOWN)
    else $error("direction fall did not step down");
  a_no_pin_xfer: assert property (bidir && ps_chg && !xfer_d |-> !start_go)
    else $error("direction toggle restarted sweep");
  a_hold_top: assert property (bidir && st == ST_UP && addr == cur_final && !ps_chg
      && !xfer_d |=> addr == $past(addr))
    else $error("address moved at final");
  a_recirc_wrap: assert property (!seq_on && !bidir && run_mode == MD_RECIRC && ram_en
      && st == ST_UP && tick && addr == cur_final && !start_go |=> addr == $past(cur_begin))
    else $error("recirculate did not wrap");
  a_seq_advance: assert property (seq_on && st == ST_UP && tick && addr == cur_final
      && cur_prof != last_prof && !start_go |=> cur_prof == $past(cur_prof) + 2'h1)
    else $error("sequencer did not advance");
  a_seq_wrap: assert property (seq_on && seq_cont && st == ST_UP && tick
      && addr == cur_final && cur_prof == last_prof && !start_go |=> cur_prof == 2'h0)
    else $error("continuous sequence did not wrap");

  c_bidir_fall: cover property (bidir && ps0_fall ##1 st == ST_DOWN);
  c_cont_turn: cover property (run_mode == MD_CONT_BIDIR && st == ST_UP ##1 st == ST_DOWN);
  c_burst_done: cover property (seq_on ##1 $rose(done));
  c_recirc: cover property (run_mode == MD_RECIRC && tick && addr == cur_final);

endmodule

/* dv/rss_host_model.sv */
/*
  Host controller model: drives the profile pins and the transfer strobe.
  Assumes the bench calls its tasks from one process in step with CLOCK.
*/
`timescale 1ns/100ps
module rss_host_model
(
  // Clock.
  input wire logic CLOCK,
  // Pins toward the device.
  output logic [1:0] PROFILE_SELECT,
  output logic UPDATE
);
  // The pins rest low until the host acts.
  initial
  begin
    PROFILE_SELECT = 2'h0;
    UPDATE = 1'b0;
  end
  // Sets the profile pins; in bidirectional mode bit zero only steers.
  task automatic set_pins(input logic [1:0] p);
    @(posedge CLOCK);
    PROFILE_SELECT <= p;
  endtask
  // Raises the strobe for three cycles so the synchroniser cannot lose it.
  task automatic pulse();
    @(posedge CLOCK);
    UPDATE <= 1'b1;
    repeat (3) @(posedge CLOCK);
    UPDATE <= 1'b0;
  endtask
endmodule

/* dv/rss_sequencer_tb.sv */
/*
  Self-checking bench of the RAM sweep address sequencer.
  Assumes the host model drives the pins and the bench owns the register port.
*/
`timescale 1ns/100ps
module rss_sequencer_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] psel;
  logic upd;
  logic [9:0] ram_addr;
  logic to_phase;
  logic active;
  logic [1:0] prof;
  logic done;
  int fails = 0;
  int n_tests = 0;
  // The clock runs at 200 MHz.
  always #2.5 clock = ~clock;
  rss_host_model i_host (.CLOCK(clock), .PROFILE_SELECT(psel), .UPDATE(upd));
  rss_sequencer i_dut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PROFILE_SELECT(psel), .UPDATE(upd), .RAM_ADDR(ram_addr),
    .RAM_TO_PHASE(to_phase), .RAM_ACTIVE(active), .ACTIVE_PROFILE(prof),
    .BURST_DONE(done));
  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  // One-cycle register write.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // One-cycle register read; the data stand only in the following cycle.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk("rdata", exp, rdata);
  endtask
  // Writes the control and address words of one segment.
  task automatic seg(input int p, input logic [2:0] m, input logic [15:0] r,
    input logic [9:0] b, input logic [9:0] f);
    wr_reg(8'h04 + 8'(4 * p), {8'h00, r, m, 5'h10});
    wr_reg(8'h14 + 8'(4 * p), {6'h00, f, 6'h00, b});
  endtask
  // Waits, bounded, for the address to show a value.
  task automatic wait_val(input logic [9:0] v);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (ram_addr !== v && n < 40);
    chk("start address", {22'h0, v}, {22'h0, ram_addr});
    if (ram_addr !== v)
      tally_and_finish();
  endtask
  // Checks the next address and the cycles spent on the previous one.
  task automatic step(input logic [9:0] v, input int per);
    logic [9:0] old;
    int n;
    old = ram_addr;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (ram_addr === old && n < 40);
    chk("next address", {22'h0, v}, {22'h0, ram_addr});
    chk("step period", per, n);
  endtask
  // Checks that the address stays put for some cycles.
  task automatic hold(input int cyc);
    logic [9:0] old;
    old = ram_addr;
    repeat (cyc) @(negedge clock);
    chk("held address", {22'h0, old}, {22'h0, ram_addr});
  endtask
  // Reset values, read-back and an unmapped offset.
  task automatic t_reset();
    chk("ram address", 32'h0, {22'h0, ram_addr});
    chk("active", 32'h0, {31'h0, active});
    chk("to phase", 32'h0, {31'h0, to_phase});
    chk("burst done", 32'h0, {31'h0, done});
    rd_reg(8'h00, 32'h00000000);
    rd_reg(8'h80, 32'h00000000);
    wr_reg(8'h80, 32'h12345678);
    rd_reg(8'h80, 32'h00000000);
  endtask
  // Continuous bidirectional sweep to phase, no-dwell set but ignored.
  task automatic t_cont_bidir();
    seg(0, 3'h3, 16'h0003, 10'h002, 10'h004);
    seg(1, 3'h4, 16'h0002, 10'h005, 10'h007);
    wr_reg(8'h00, 32'hc0000000);
    rd_reg(8'h00, 32'hc0000000);
    i_host.pulse();
    wait_val(10'h002);
    chk("to phase", 32'h1, {31'h0, to_phase});
    chk("active", 32'h1, {31'h0, active});
    step(10'h003, 3);
    step(10'h004, 3);
    step(10'h003, 3);
    step(10'h002, 3);
    step(10'h003, 3);
  endtask
  // Profile pin change mid-sweep starts a recirculating sweep.
  task automatic t_recirc();
    i_host.set_pins(2'h1);
    wait_val(10'h005);
    chk("profile", 32'h1, {30'h0, prof});
    step(10'h006, 2);
    step(10'h007, 2);
    step(10'h005, 2);
    step(10'h006, 2);
  endtask
  // Bidirectional ramp steered by profile bit zero.
  task automatic t_bidir();
    seg(0, 3'h2, 16'h0002, 10'h008, 10'h00a);
    i_host.set_pins(2'h3);
    i_host.pulse();
    wait_val(10'h008);
    chk("profile", 32'h0, {30'h0, prof});
    step(10'h009, 2);
    step(10'h00a, 2);
    hold(12);
    i_host.set_pins(2'h1);
    hold(12);
    i_host.set_pins(2'h0);
    wait_val(10'h009);
    step(10'h008, 2);
    hold(12);
  endtask
  // Direct switch and the open mode codes hold the beginning address.
  task automatic t_direct();
    for (int m = 5; m <= 8; m++)
    begin
      seg(0, 3'(m), 16'h0001, 10'(12 + m), 10'h01f);
      i_host.pulse();
      wait_val(10'(12 + m));
      hold(8);
    end
    // Mode 001 decodes as ramp-up: steps to the final address and stops there.
    seg(2, 3'h1, 16'h0002, 10'h040, 10'h041);
    i_host.pulse();
    i_host.set_pins(2'h2);
    wait_val(10'h040);
    step(10'h041, 2);
    hold(8);
  endtask
  // Internal sequencing, single burst then continuous.
  task automatic t_internal();
    seg(0, 3'h3, 16'h0001, 10'h028, 10'h02a);
    seg(1, 3'h4, 16'h0001, 10'h032, 10'h033);
    wr_reg(8'h00, 32'h88000000);
    i_host.set_pins(2'h3);
    i_host.pulse();
    wait_val(10'h028);
    step(10'h029, 1);
    step(10'h02a, 1);
    step(10'h032, 1);
    chk("profile", 32'h1, {30'h0, prof});
    step(10'h033, 1);
    hold(10);
    chk("burst done", 32'h1, {31'h0, done});
    rd_reg(8'h24, 32'h00121033);
    wr_reg(8'h00, 32'ha0000000);
    i_host.pulse();
    wait_val(10'h028);
    chk("burst done", 32'h0, {31'h0, done});
    chk("to phase", 32'h0, {31'h0, to_phase});
    step(10'h029, 1);
    step(10'h02a, 1);
    step(10'h032, 1);
    step(10'h033, 1);
    step(10'h028, 1);
    chk("profile", 32'h0, {30'h0, prof});
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_reset();
    t_cont_bidir();
    t_recirc();
    t_bidir();
    t_direct();
    t_internal();
    tally_and_finish();
  end
endmodule
